// ==== mroe_chk.sv ====
// concurrent checks on the execute block ports
`timescale 1ns/10ps
module mroe_chk
    import mroe_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    input wire logic [13:0] instr,
    input wire logic instr_valid,
    input wire logic [12:0] stack_top_entry,
    input wire logic [6:0] file_rd_addr,
    input wire logic [7:0] file_rd_data,
    input wire logic stack_pop,
    input wire logic [12:0] pc,
    input wire logic fetch_flush,
    input wire logic [7:0] acc,
    input wire logic file_we,
    input wire logic [6:0] file_waddr,
    input wire logic [7:0] file_wdata,
    input wire logic [7:0] option_reg,
    input wire logic [7:0] interrupt_control_reg
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);
    wire tk = instr_valid && !fetch_flush;
    AST_LIT: assert property (tk && (instr & LIT_MASK) == LIT_PAT
        |=> acc == $past(instr[7:0])) else $error("literal load wrong");
    AST_STO: assert property (tk && (instr & STORE_MASK) == STORE_PAT
        |=> file_we && file_waddr == $past(instr[6:0]) && file_wdata == $past(acc))
        else $error("store wrong");
    AST_RET: assert property (tk && instr == IRET_OP
        |=> pc == $past(stack_top_entry) && stack_pop) else $error("return target wrong");
    AST_GIE: assert property (tk && instr == IRET_OP
        |=> interrupt_control_reg[GIE_BIT]) else $error("enable not set");
    AST_TWO: assert property (tk && instr == IRET_OP
        |=> fetch_flush ##1 !fetch_flush && $stable(pc)) else $error("return length wrong");
    AST_OPT: assert property (tk && instr == OPT_OP
        |=> option_reg == $past(acc)) else $error("option load wrong");
    AST_RD: assert property (file_rd_addr == OPTION_ADDR
        |-> file_rd_data == option_reg) else $error("option read wrong");
    AST_IDL: assert property (tk && (instr & IDLE_MASK) == IDLE_PAT
        |=> pc == $past(pc) + 13'h0001 && $stable(acc) && !file_we && !stack_pop)
        else $error("idle changed state");
endmodule

// ==== mroe_decode.sv ====
// opcode classifier for the move/return/option execute block
`timescale 1ns/10ps
module mroe_decode
    import mroe_pkg::*;
(
    input wire logic [13:0] instr,
    output mroe_op_e op
);
    function automatic logic hit(input logic [13:0] i, input logic [13:0] m,
                                 input logic [13:0] p);
        hit = (i & m) == p;
    endfunction

    always_comb begin
        if (hit(instr, LIT_MASK, LIT_PAT)) begin
            op = MROE_OP_LIT;
        end else if (hit(instr, STORE_MASK, STORE_PAT)) begin
            op = MROE_OP_STORE;
        end else if (instr == IRET_OP) begin
            op = MROE_OP_IRET;
        end else if (instr == OPT_OP) begin
            op = MROE_OP_OPT;
        end else begin
            op = MROE_OP_NONE;
        end
    end
endmodule

// ==== mroe_exec.sv ====
// execute stage for literal load, store, idle, interrupt return and option load
// Summary of operation
// - literal load copies the 8-bit immediate into the accumulator, flags untouched.
// - the two don't-care bits of the literal load opcode are ignored.
// - store writes the accumulator to the addressed file register in one cycle.
// - interrupt return pops the stack and loads the popped top into the counter.
// - interrupt return sets bit 7 of the interrupt control register.
// - interrupt return is one word but takes two instruction cycles.
// - legacy option opcode copies the accumulator into the option register.
// - option register is also reachable as an ordinary addressed file register.
`timescale 1ns/10ps
module mroe_exec
    import mroe_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    // instruction word from fetch
    input wire logic [13:0] instr,
    input wire logic instr_valid,
    // return stack and file read path
    input wire logic [12:0] stack_top_entry,
    input wire logic [6:0] file_rd_addr,
    input wire logic [7:0] file_rd_data_ext,
    // results toward the core
    output logic [7:0] file_rd_data,
    output logic stack_pop,
    output logic [12:0] pc,
    output logic fetch_flush,
    output logic [7:0] acc,
    output logic file_we,
    output logic [6:0] file_waddr,
    output logic [7:0] file_wdata,
    output logic [7:0] option_reg,
    output logic [7:0] interrupt_control_reg,
    output logic global_irq_enable,
    output logic flags_we
);
    mroe_op_e op;
    mroe_state_e state_r;
    logic [7:0] acc_r;
    logic [7:0] option_r;
    logic [7:0] intctl_r;
    logic [12:0] pc_r;
    logic file_we_r;
    logic [6:0] file_waddr_r;
    logic [7:0] file_wdata_r;
    logic pop_r;
    logic exec;
    logic ret_second;

    // decoded strobes and operand fields of the word being taken
    logic take_lit;
    logic take_store;
    logic take_iret;
    logic take_opt;
    logic take_other;
    logic [7:0] lit_field;
    logic [6:0] faddr_field;
    logic [12:0] pc_inc;

    // true when a file address selects the option register
    function automatic logic is_option_addr(input logic [6:0] a);
        is_option_addr = a == OPTION_ADDR;
    endfunction

    // classify the word; the decoder holds the priority between patterns
    mroe_decode u_decode (
        .instr(instr),
        .op(op)
    );

    // the word fetched behind a return is dropped in its second cycle
    assign ret_second = state_r == MROE_ST_FLUSH;
    assign exec = instr_valid && !ret_second;

    // one strobe per instruction kind
    assign take_lit = exec && op == MROE_OP_LIT;
    assign take_store = exec && op == MROE_OP_STORE;
    assign take_iret = exec && op == MROE_OP_IRET;
    assign take_opt = exec && op == MROE_OP_OPT;
    // idle and every opcode outside this subset only step the counter
    assign take_other = exec && op == MROE_OP_NONE;

    // operand fields
    assign lit_field = instr[7:0];
    assign faddr_field = instr[6:0];
    assign pc_inc = pc_r + 13'h0001;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            state_r <= MROE_ST_EXEC;
        end else begin
            unique case (state_r)
                MROE_ST_EXEC: begin
                    if (take_iret) begin
                        state_r <= MROE_ST_FLUSH;
                    end
                end
                MROE_ST_FLUSH: begin
                    state_r <= MROE_ST_EXEC;
                end
                default: begin
                    // a corrupted code falls back to normal execution
                    state_r <= MROE_ST_EXEC;
                end
            endcase
        end
    end

    // literal load; no flag write is raised for it
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            acc_r <= ACC_RST;
        end else if (take_lit) begin
            acc_r <= lit_field;
        end
    end

    // write strobe stands for one cycle after a store is taken
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            file_we_r <= 1'b0;
        end else begin
            file_we_r <= take_store;
        end
    end

    // address of the store, held beside the write strobe
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            file_waddr_r <= 7'h00;
        end else if (take_store) begin
            file_waddr_r <= faddr_field;
        end
    end

    // the accumulator as it stands, so a literal load just before is seen
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            file_wdata_r <= 8'h00;
        end else if (take_store) begin
            file_wdata_r <= acc_r;
        end
    end

    // legacy load and an addressed store both reach the option register
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            option_r <= OPTION_RST;
        end else if (take_opt) begin
            option_r <= acc_r;
        end else if (take_store && is_option_addr(faddr_field)) begin
            option_r <= acc_r;
        end
    end

    // nothing here clears the enable; interrupt entry owns that
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            intctl_r <= INTCTL_RST;
        end else if (take_iret) begin
            intctl_r[GIE_BIT] <= 1'b1;
        end
    end

    // pop pulse tells the stack to drop the entry just used
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            pop_r <= 1'b0;
        end else begin
            pop_r <= take_iret;
        end
    end

    // the counter holds through the dropped second cycle of a return
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            pc_r <= PC_RST;
        end else begin
            unique case (1'b1)
                take_iret: begin
                    pc_r <= stack_top_entry;
                end
                take_other: begin
                    pc_r <= pc_inc;
                end
                take_lit, take_store, take_opt: begin
                    pc_r <= pc_inc;
                end
                default: begin
                    pc_r <= pc_r;
                end
            endcase
        end
    end

    // option register read back through the ordinary file path
    always_comb begin
        if (is_option_addr(file_rd_addr)) begin
            file_rd_data = option_r;
        end else begin
            file_rd_data = file_rd_data_ext;
        end
    end

    // registered results
    assign acc = acc_r;
    assign option_reg = option_r;
    assign interrupt_control_reg = intctl_r;
    assign global_irq_enable = intctl_r[GIE_BIT];
    assign file_we = file_we_r;
    assign file_waddr = file_waddr_r;
    assign file_wdata = file_wdata_r;

    // return handshake toward fetch and the stack
    assign pc = pc_r;
    assign stack_pop = pop_r;
    assign fetch_flush = ret_second;

    // none of these instructions touch the status flags
    assign flags_we = 1'b0;
endmodule

// ==== mroe_fetch_model.sv ====
// fetch-side partner: return stack top and external file data
`timescale 1ns/10ps
module mroe_fetch_model (
    input wire logic clk,
    input wire logic rst,
    input wire logic stack_pop,
    output logic [12:0] stack_top_entry,
    output logic [7:0] file_rd_data_ext
);
    // a new top appears once the old one is popped
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            stack_top_entry <= 13'h1A5C;
        end else if (stack_pop) begin
            stack_top_entry <= stack_top_entry - 13'h0111;
        end
    end
    // swaps between 8'h3C and 8'hC4 every cycle, so a value one cycle stale never matches
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            file_rd_data_ext <= 8'h3C;
        end else begin
            file_rd_data_ext <= ~file_rd_data_ext + 8'h01;
        end
    end
endmodule

// ==== mroe_pkg.sv ====
// constants and types shared by the move/return/option execute block
package mroe_pkg;
    localparam int INSTR_W = 14;
    localparam int DATA_W = 8;
    localparam int FADDR_W = 7;
    localparam int PC_W = 13;
    // opcode patterns and masks
    localparam logic [13:0] LIT_MASK = 14'h3C00;
    localparam logic [13:0] LIT_PAT = 14'h3000;
    localparam logic [13:0] STORE_MASK = 14'h3F80;
    localparam logic [13:0] STORE_PAT = 14'h0080;
    localparam logic [13:0] IDLE_MASK = 14'h3F9F;
    localparam logic [13:0] IDLE_PAT = 14'h0000;
    localparam logic [13:0] IRET_OP = 14'h0009;
    localparam logic [13:0] OPT_OP = 14'h0062;
    // file address of the option register and bit of the global enable
    localparam logic [6:0] OPTION_ADDR = 7'h01;
    localparam int GIE_BIT = 7;
    localparam logic [7:0] ACC_RST = 8'h00;
    localparam logic [7:0] OPTION_RST = 8'hFF;
    localparam logic [7:0] INTCTL_RST = 8'h00;
    localparam logic [12:0] PC_RST = 13'h0000;
    typedef enum logic [4:0] {
        MROE_OP_NONE = 5'b00001,
        MROE_OP_LIT = 5'b00010,
        MROE_OP_STORE = 5'b00100,
        MROE_OP_IRET = 5'b01000,
        MROE_OP_OPT = 5'b10000
    } mroe_op_e;
    typedef enum logic [1:0] {
        MROE_ST_EXEC = 2'b01,
        MROE_ST_FLUSH = 2'b10
    } mroe_state_e;
endpackage

// ==== testbench.sv ====
// self-checking bench for the execute block
`timescale 1ns/10ps
module testbench;
    import mroe_pkg::*;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic [13:0] instr = 14'h0000;
    logic instr_valid = 1'b0;
    logic [6:0] file_rd_addr = 7'h00;
    logic [12:0] stack_top_entry, pc, pc_exp, t;
    logic [7:0] file_rd_data_ext, file_rd_data, acc, file_wdata, option_reg, interrupt_control_reg;
    logic [6:0] file_waddr;
    logic stack_pop, fetch_flush, file_we, global_irq_enable, flags_we;
    int fails = 0;
    int check_count = 0;
    always #2 clk = ~clk;
    mroe_exec i_dut (
        .clk(clk),
        .rst(rst),
        .instr(instr),
        .instr_valid(instr_valid),
        .stack_top_entry(stack_top_entry),
        .file_rd_addr(file_rd_addr),
        .file_rd_data_ext(file_rd_data_ext),
        .file_rd_data(file_rd_data),
        .stack_pop(stack_pop),
        .pc(pc),
        .fetch_flush(fetch_flush),
        .acc(acc),
        .file_we(file_we),
        .file_waddr(file_waddr),
        .file_wdata(file_wdata),
        .option_reg(option_reg),
        .interrupt_control_reg(interrupt_control_reg),
        .global_irq_enable(global_irq_enable),
        .flags_we(flags_we)
    );
    mroe_fetch_model i_far (
        .clk(clk),
        .rst(rst),
        .stack_pop(stack_pop),
        .stack_top_entry(stack_top_entry),
        .file_rd_data_ext(file_rd_data_ext)
    );
    task chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            fails++;
            $display("MISMATCH %s exp %h got %h", nm, exp, got);
        end
    endtask
    task issue(input logic [13:0] w);
        instr = w;
        instr_valid = 1'b1;
        @(posedge clk);
        #1;
        pc_exp = pc_exp + 13'h0001;
        chk("pc", 16'(pc), 16'(pc_exp));
        chk("flags we", 16'(flags_we), 16'h0000);
    endtask
    task t_lit;
        for (int i = 0; i < 4; i++) begin
            issue(LIT_PAT | 14'(i << 8) | 14'(i * 85));
            chk("acc", 16'(acc), 16'(i * 85));
        end
    endtask
    task t_sto;
        issue(LIT_PAT | 14'h00C3);
        issue(STORE_PAT | 14'h007F);
        chk("store", {file_we, file_waddr, file_wdata}, {1'b1, 7'h7F, 8'hC3});
    endtask
    task t_opt;
        issue(LIT_PAT | 14'h004F);
        file_rd_addr = OPTION_ADDR;
        issue(OPT_OP);
        chk("option", 16'(option_reg), 16'h004F);
        chk("rd opt", 16'(file_rd_data), 16'h004F);
        issue(LIT_PAT | 14'h0096);
        issue(STORE_PAT | 14'(OPTION_ADDR));
        chk("rd opt", 16'(file_rd_data), 16'h0096);
        file_rd_addr = 7'h02;
        issue(IDLE_PAT);
        chk("rd ext", 16'(file_rd_data), 16'(file_rd_data_ext));
    endtask
    task t_rst;
        instr_valid = 1'b0;
        rst = 1'b1;
        @(posedge clk);
        #1;
        chk("rst pc", {pc, interrupt_control_reg}, {PC_RST, INTCTL_RST});
        chk("rst out", {fetch_flush, stack_pop, file_we, acc, option_reg},
            {3'b000, ACC_RST, OPTION_RST});
        rst = 1'b0;
        pc_exp = PC_RST;
        issue(LIT_PAT | 14'h005A);
        chk("acc", 16'(acc), 16'h005A);
    endtask
    task t_iret;
        for (int i = 0; i < 2; i++) begin
            issue(LIT_PAT | 14'h0033);
            t = stack_top_entry;
            pc_exp = t - 13'h0001;
            issue(IRET_OP);
            instr = LIT_PAT | 14'h0077;
            chk("ret", {interrupt_control_reg[GIE_BIT], global_irq_enable, stack_pop,
                fetch_flush}, 16'h000F);
            @(posedge clk);
            #1;
            chk("dead", {fetch_flush, pc, acc}, {1'b0, t, 8'h33});
        end
    endtask
    task t_idle;
        for (int i = 0; i < 4; i++) begin
            issue(14'(i * 32));
            chk("idle", {file_we, stack_pop, acc}, {2'b00, 8'h33});
        end
    endtask
    task finish_test;
        $display("fails %0d checks %0d", fails, check_count);
        if (fails == 0 && check_count > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    initial begin
        pc_exp = PC_RST;
        repeat (3) @(posedge clk);
        #1 rst = 1'b0;
        chk("rst", {acc, option_reg}, {ACC_RST, OPTION_RST});
        t_lit;
        t_sto;
        t_opt;
        t_iret;
        t_idle;
        t_rst;
        finish_test;
    end
    initial begin
        #20000;
        fails++;
        finish_test;
    end
endmodule
bind mroe_exec mroe_chk i_chk (
    .clk(clk),
    .rst(rst),
    .instr(instr),
    .instr_valid(instr_valid),
    .stack_top_entry(stack_top_entry),
    .file_rd_addr(file_rd_addr),
    .file_rd_data(file_rd_data),
    .stack_pop(stack_pop),
    .pc(pc),
    .fetch_flush(fetch_flush),
    .acc(acc),
    .file_we(file_we),
    .file_waddr(file_waddr),
    .file_wdata(file_wdata),
    .option_reg(option_reg),
    .interrupt_control_reg(interrupt_control_reg)
);
